/* File: rtl/flash_seq_pkg.sv */
// constants for the flash command sequencer
// assumes a byte-wide memory bus from the cpu and a 250 MHz system clock
package flash_seq_pkg;
	localparam logic [3:0]  CMD_NIB_MIN     = 4'h8;
	localparam logic [11:0] CMD_OFS_A       = 12'h555;
	localparam logic [11:0] CMD_OFS_B       = 12'hAAA;
	localparam logic [7:0]  KEY_UNLOCK1     = 8'hAA;
	localparam logic [7:0]  KEY_UNLOCK2     = 8'h55;
	localparam logic [7:0]  CMD_PROGRAM     = 8'hA0;
	localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0]  CMD_SECURITY    = 8'hA5;
	localparam logic [7:0]  CMD_ID_ENTRY    = 8'h90;
	localparam logic [7:0]  CMD_ID_EXIT     = 8'hF0;
	localparam logic [7:0]  CMD_SECTOR      = 8'h30;
	localparam logic [7:0]  CMD_CHIP        = 8'h10;
	localparam logic [7:0]  SEC_DATA        = 8'h00;
	localparam logic [15:0] SEC_ADDR        = 16'hFF7F;
	localparam logic [15:0] ID_VENDOR_ADDR  = 16'hF000;
	localparam logic [15:0] ID_FLASH_ADDR   = 16'hF001;
	localparam logic [15:0] FLASH_BASE      = 16'h8000;
	localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
	localparam logic [7:0]  SEC_ON_BYTE     = 8'h00;
	localparam logic [2:0]  WP_ENABLE       = 3'b101;
	localparam logic [2:0]  WP_DISABLE      = 3'b010;
	localparam logic [7:0]  COMMIT_KEY      = 8'hD5;
	localparam logic [1:0]  AREA_DATA       = 2'b00;
	localparam logic [1:0]  AREA_CODE       = 2'b10;
	localparam int          TOGGLE_BIT      = 6;
	localparam int          SECTOR_LSB      = 10;
	localparam int          CLK_MHZ         = 250;
	localparam int          PROG_TIME_US    = 40;
	localparam int          ERASE_TIME_MS   = 40;
	localparam int          PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
	localparam int          ERASE_CYCLES    = ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam logic [1:0]  MODE_MCU        = 2'd0;
	localparam logic [1:0]  MODE_SERIAL     = 2'd1;
	localparam logic [1:0]  MODE_PARALLEL   = 2'd2;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_U1    = 4'b0001,
		ST_U2    = 4'b0010,
		ST_PROG4 = 4'b0011,
		ST_SEC4  = 4'b0100,
		ST_E4    = 4'b0101,
		ST_E5    = 4'b0110,
		ST_E6    = 4'b0111,
		ST_BUSY  = 4'b1000
	} seq_state_t;
	typedef enum logic [1:0] {
		OP_PROG  = 2'b00,
		OP_SECT  = 2'b01,
		OP_CHIP  = 2'b10,
		OP_SEC   = 2'b11
	} op_kind_t;
endpackage

/* File: rtl/flash_command_sequencer.sv */
// flash command sequencer: decodes cpu write sequences, times operations,
// drives the array's program/erase strobes and shapes read data.
// assumes the array answers reads combinationally on i_array_rdata and
// the cpu keeps strobes one cycle long.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer
	import flash_seq_pkg::*;
#(
	parameter int          ERASE_CNT = ERASE_CYCLES,
	parameter logic [7:0]  VENDOR_ID = 8'h5A, // arbitrary value
	parameter logic [7:0]  FLASH_ID  = 8'h3C  // arbitrary value
) (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset,
	// cpu memory bus
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [7:0]       o_rdata,
	// control register writes
	input  wire logic        i_ctl_wr,
	input  wire logic [2:0]  i_write_protect_mode,
	input  wire logic [1:0]  i_area_select,
	input  wire logic        i_commit_wr,
	input  wire logic [7:0]  i_commit_key,
	input  wire logic [1:0]  i_op_mode,
	input  wire logic        i_serial_overwrite_req,
	input  wire logic        i_ram_loader_req,
	// array interface
	input  wire logic [7:0]  i_array_rdata,
	output logic             o_array_prog,
	output logic             o_array_sect_erase,
	output logic             o_array_chip_erase,
	output logic [15:0]      o_array_addr,
	output logic [7:0]       o_array_wdata,
	// status
	output logic             o_busy,
	output logic             o_id_mode,
	output logic             o_secured,
	output logic             o_cmd_enabled,
	output logic [1:0]       o_area_active,
	output logic             o_serial_overwrite_ok,
	output logic             o_ram_loader_ok
);
	seq_state_t  state_r, state_nxt;
	op_kind_t    op_r, op_nxt;
	logic [2:0]  wp_pend_r, wp_pend_nxt;
	logic [1:0]  area_pend_r, area_pend_nxt;
	logic        cmd_en_r, cmd_en_nxt;
	logic [1:0]  area_r, area_nxt;
	logic        sec_r, sec_nxt;
	logic        id_r, id_nxt;
	logic        tog_r, tog_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [15:0] op_addr_r, op_addr_nxt;
	logic [7:0]  op_data_r, op_data_nxt;
	logic        prog_r, prog_nxt;
	logic        sect_r, sect_nxt;
	logic        chip_r, chip_nxt;
	logic [7:0]  rdata_r, rdata_nxt;
	logic        first_rd_r, first_rd_nxt;

	logic        hi_ok, at_a, at_b, wr_cmd, busy, par_block;
	logic [7:0]  rd_src;

	assign hi_ok     = i_addr[15:12] >= CMD_NIB_MIN;
	assign at_a      = hi_ok && (i_addr[11:0] == CMD_OFS_A);
	assign at_b      = hi_ok && (i_addr[11:0] == CMD_OFS_B);
	assign wr_cmd    = i_wr && cmd_en_r;
	assign busy      = (state_r == ST_BUSY);
	assign par_block = sec_r && (i_op_mode == MODE_PARALLEL);

	// write protect and area select take effect only on the commit key
	always_comb begin
		wp_pend_nxt   = wp_pend_r;
		area_pend_nxt = area_pend_r;
		cmd_en_nxt    = cmd_en_r;
		area_nxt      = area_r;
		if (i_ctl_wr) begin
			wp_pend_nxt   = i_write_protect_mode;
			area_pend_nxt = i_area_select;
		end
		if (i_commit_wr && i_commit_key == COMMIT_KEY) begin
			if (wp_pend_r == WP_ENABLE) begin
				cmd_en_nxt = 1'b1;
			end else if (wp_pend_r == WP_DISABLE) begin
				cmd_en_nxt = 1'b0;
			end
			if (area_pend_r == AREA_DATA || area_pend_r == AREA_CODE) begin
				area_nxt = area_pend_r;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			wp_pend_r   <= WP_DISABLE;
			area_pend_r <= AREA_DATA;
			cmd_en_r    <= 1'b0;
			area_r      <= AREA_DATA;
		end else begin
			wp_pend_r   <= wp_pend_nxt;
			area_pend_r <= area_pend_nxt;
			cmd_en_r    <= cmd_en_nxt;
			area_r      <= area_nxt;
		end
	end

	// sequence decoder and operation timer
	always_comb begin
		state_nxt   = state_r;
		op_nxt      = op_r;
		sec_nxt     = sec_r;
		id_nxt      = id_r;
		cnt_nxt     = cnt_r;
		op_addr_nxt = op_addr_r;
		op_data_nxt = op_data_r;
		prog_nxt    = 1'b0;
		sect_nxt    = 1'b0;
		chip_nxt    = 1'b0;
		case (state_r)
		ST_IDLE: begin
			if (wr_cmd && !par_block) begin
				if (i_wdata == CMD_ID_EXIT) begin
					id_nxt = 1'b0;
				end else if (at_a && i_wdata == KEY_UNLOCK1) begin
					state_nxt = ST_U1;
				end
			end
		end
		ST_U1: begin
			if (wr_cmd) begin
				state_nxt = (at_b && i_wdata == KEY_UNLOCK2) ? ST_U2 : ST_IDLE;
			end
		end
		ST_U2: begin
			if (wr_cmd) begin
				state_nxt = ST_IDLE;
				if (at_a && i_wdata == CMD_PROGRAM) begin
					state_nxt = ST_PROG4;
				end else if (at_a && i_wdata == CMD_ERASE_SETUP) begin
					state_nxt = ST_E4;
				end else if (at_a && i_wdata == CMD_SECURITY) begin
					state_nxt = ST_SEC4;
				end else if (at_a && i_wdata == CMD_ID_ENTRY) begin
					id_nxt = 1'b1;
				end
			end
		end
		ST_PROG4: begin
			if (wr_cmd) begin
				state_nxt = ST_IDLE;
				if (i_addr >= FLASH_BASE) begin
					op_addr_nxt = i_addr;
					op_data_nxt = i_wdata;
					op_nxt      = OP_PROG;
					prog_nxt    = 1'b1;
					cnt_nxt     = 32'(PROG_CYCLES - 1);
					state_nxt   = ST_BUSY;
				end
			end
		end
		ST_SEC4: begin
			if (wr_cmd) begin
				state_nxt = ST_IDLE;
				if (i_addr == SEC_ADDR && i_wdata == SEC_DATA) begin
					op_nxt    = OP_SEC;
					cnt_nxt   = 32'(PROG_CYCLES - 1);
					state_nxt = ST_BUSY;
				end
			end
		end
		ST_E4: begin
			if (wr_cmd) begin
				state_nxt = (at_a && i_wdata == KEY_UNLOCK1) ? ST_E5 : ST_IDLE;
			end
		end
		ST_E5: begin
			if (wr_cmd) begin
				state_nxt = (at_b && i_wdata == KEY_UNLOCK2) ? ST_E6 : ST_IDLE;
			end
		end
		ST_E6: begin
			if (wr_cmd) begin
				state_nxt = ST_IDLE;
				if (i_wdata == CMD_SECTOR && i_addr >= FLASH_BASE
					&& i_op_mode != MODE_PARALLEL) begin
					op_addr_nxt = {i_addr[15:SECTOR_LSB], 10'h000};
					op_nxt      = OP_SECT;
					sect_nxt    = 1'b1;
					cnt_nxt     = 32'(ERASE_CNT - 1);
					state_nxt   = ST_BUSY;
				end else if (i_wdata == CMD_CHIP && at_a) begin
					op_nxt    = OP_CHIP;
					chip_nxt  = 1'b1;
					cnt_nxt   = 32'(ERASE_CNT - 1);
					state_nxt = ST_BUSY;
				end
			end
		end
		ST_BUSY: begin
			// writes during the operation are dropped
			if (cnt_r == 32'd0) begin
				state_nxt = ST_IDLE;
				if (op_r == OP_SEC) begin
					sec_nxt = 1'b1;
				end else if (op_r == OP_CHIP) begin
					sec_nxt = 1'b0;
				end
			end else begin
				cnt_nxt = cnt_r - 32'd1;
			end
		end
		default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_r   <= ST_IDLE;
			op_r      <= OP_PROG;
			sec_r     <= 1'b0;
			id_r      <= 1'b0;
			cnt_r     <= 32'd0;
			op_addr_r <= 16'h0000;
			op_data_r <= 8'h00;
			prog_r    <= 1'b0;
			sect_r    <= 1'b0;
			chip_r    <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			op_r      <= op_nxt;
			sec_r     <= sec_nxt;
			id_r      <= id_nxt;
			cnt_r     <= cnt_nxt;
			op_addr_r <= op_addr_nxt;
			op_data_r <= op_data_nxt;
			prog_r    <= prog_nxt;
			sect_r    <= sect_nxt;
			chip_r    <= chip_nxt;
		end
	end

	// read path: id values, toggle bit, security blocking
	always_comb begin
		tog_nxt = tog_r;
		rd_src  = i_array_rdata;
		if (id_r) begin
			if (i_addr == ID_VENDOR_ADDR) begin
				rd_src = VENDOR_ID;
			end else if (i_addr == ID_FLASH_ADDR) begin
				rd_src = FLASH_ID;
			end else if (i_addr == SEC_ADDR) begin
				rd_src = sec_r ? SEC_ON_BYTE : ERASED_BYTE;
			end
		end
		if (par_block) begin
			rd_src = 8'h00;
		end
		if (state_nxt == ST_BUSY && !busy) begin
			tog_nxt = 1'b0;
		end
		rdata_nxt = rdata_r;
		if (i_rd) begin
			rdata_nxt = rd_src;
			if (busy && cmd_en_r) begin
				rdata_nxt[TOGGLE_BIT] = ~tog_r;
				tog_nxt = ~tog_r;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			tog_r   <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			tog_r   <= tog_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata               = rdata_r;
	assign o_array_prog          = prog_r;
	assign o_array_sect_erase    = sect_r;
	assign o_array_chip_erase    = chip_r;
	assign o_array_addr          = op_addr_r;
	assign o_array_wdata         = op_data_r;
	assign o_busy                = busy;
	assign o_id_mode             = id_r;
	assign o_secured             = sec_r;
	assign o_cmd_enabled         = cmd_en_r;
	assign o_area_active         = area_r;
	assign o_serial_overwrite_ok = i_serial_overwrite_req && !(sec_r && i_op_mode == MODE_SERIAL);
	assign o_ram_loader_ok       = i_ram_loader_req && !(sec_r && i_op_mode == MODE_SERIAL);

	// checker helper: no read seen since the last idle cycle; kept apart from the toggle
	// logic so that the first-read check does not just mirror it
	always_comb begin
		first_rd_nxt = first_rd_r;
		if (!busy) begin
			first_rd_nxt = 1'b1;
		end else if (i_rd) begin
			first_rd_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			first_rd_r <= 1'b1;
		end else begin
			first_rd_r <= first_rd_nxt;
		end
	end

	// checks
	AST_PROG_START: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		$rose(prog_r) |-> busy && op_r == OP_PROG && op_addr_r >= FLASH_BASE)
		else $error("program strobe without busy program");
	AST_SEQ_BLOCK: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		busy |=> !prog_r && !sect_r && !chip_r)
		else $error("operation started while busy");
	AST_WP_IGNORE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		!cmd_en_r && state_r == ST_IDLE |=> state_r == ST_IDLE || busy)
		else $error("sequence advanced while protected");
	AST_TOGGLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		busy && cmd_en_r && i_rd ##1 busy && cmd_en_r && i_rd
		|=> o_rdata[TOGGLE_BIT] != $past(o_rdata[TOGGLE_BIT]))
		else $error("toggle bit did not invert");
	AST_FIRST_ONE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		busy && i_rd && cmd_en_r && first_rd_r |=> o_rdata[TOGGLE_BIT])
		else $error("first toggle read not one");
	AST_SEC_ID: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		i_rd && id_r && !sec_r && !busy && i_addr == SEC_ADDR |=> o_rdata == ERASED_BYTE)
		else $error("security status wrong");
	AST_SEC_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		$fell(sec_r) |-> $past(op_r) == OP_CHIP && $past(busy))
		else $error("security cleared without chip erase");
	AST_PARALLEL: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		$rose(sect_r) |-> $past(i_op_mode) != MODE_PARALLEL)
		else $error("sector erase in parallel mode");
	AST_SECTOR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		$rose(sect_r) |-> op_addr_r[9:0] == 10'h000)
		else $error("sector address not aligned");
	AST_PAR_READ: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		i_rd && !busy && sec_r && i_op_mode == MODE_PARALLEL |=> o_rdata == 8'h00)
		else $error("array read while secured in parallel mode");
	COV_PROG: cover property (@(posedge i_sys_clk) $rose(prog_r));
	COV_SECT: cover property (@(posedge i_sys_clk) $rose(sect_r));
	COV_CHIP: cover property (@(posedge i_sys_clk) $rose(chip_r));
	COV_SEC: cover property (@(posedge i_sys_clk) $rose(sec_r));
	COV_ID: cover property (@(posedge i_sys_clk) $fell(id_r));
endmodule
`default_nettype wire

/* File: tb/flash_array_model.sv */
// behavioural flash array behind the sequencer's array port
// assumes one-cycle strobes; read data follows the bus address at once
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
	// clock
	input  wire logic        i_sys_clk,
	// strobes from the sequencer
	input  wire logic        i_prog,
	input  wire logic        i_sect,
	input  wire logic        i_chip,
	input  wire logic [15:0] i_waddr,
	input  wire logic [7:0]  i_wdata,
	// read side
	input  wire logic [15:0] i_addr,
	output logic [7:0]       o_rdata
);
	logic [7:0] mem [0:65535];
	initial begin
		for (int k = 0; k < 65536; k++) begin
			mem[k] = 8'hFF;
		end
	end
	assign o_rdata = mem[i_addr];
	always @(posedge i_sys_clk) begin
		// programming only clears bits, as a real cell does
		if (i_prog) begin
			mem[i_waddr] = mem[i_waddr] & i_wdata;
		end
		if (i_sect) begin
			for (int k = 0; k < 1024; k++) begin
				mem[{i_waddr[15:10], 10'h000} + k] = 8'hFF;
			end
		end
		if (i_chip) begin
			for (int k = 32768; k < 65536; k++) begin
				mem[k] = 8'hFF;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/flash_command_sequencer_bench.sv */
// self-checking bench for the flash command sequencer
// assumes the array model above; erase count shortened to keep the run brief
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer_bench;
	import flash_seq_pkg::*;
	localparam int ECNT  = 20;
	localparam int LIMIT = 90000;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        wr  = 1'b0;
	logic        rd  = 1'b0;
	logic        ctl = 1'b0;
	logic        cmt = 1'b0;
	logic        req = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wd  = 8'h00;
	logic [7:0]  key = 8'h00;
	logic [2:0]  wpm = 3'b000;
	logic [1:0]  ar  = 2'b00;
	logic [1:0]  opm = 2'b00;
	logic [7:0]  ard, rdata, awd, v, d;
	logic [15:0] aaddr, a, b;
	logic        prog, sect, chip, busy, idm, sec, cen, sok, rok;
	logic [1:0]  aact;
	logic [7:0]  m [int];
	int          err_count = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          t0;
	always #2 clk = ~clk;
	flash_command_sequencer #(.ERASE_CNT(ECNT)) i_flash_command_sequencer (
		.i_sys_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_ctl_wr(ctl), .i_write_protect_mode(wpm),
		.i_area_select(ar), .i_commit_wr(cmt), .i_commit_key(key), .i_op_mode(opm),
		.i_serial_overwrite_req(req), .i_ram_loader_req(req), .i_array_rdata(ard),
		.o_array_prog(prog), .o_array_sect_erase(sect), .o_array_chip_erase(chip),
		.o_array_addr(aaddr), .o_array_wdata(awd), .o_busy(busy), .o_id_mode(idm),
		.o_secured(sec), .o_cmd_enabled(cen), .o_area_active(aact),
		.o_serial_overwrite_ok(sok), .o_ram_loader_ok(rok));
	flash_array_model i_flash_array_model (
		.i_sys_clk(clk), .i_prog(prog), .i_sect(sect), .i_chip(chip),
		.i_waddr(aaddr), .i_wdata(awd), .i_addr(addr), .o_rdata(ard));
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_count++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] mv(input logic [15:0] x);
		return m.exists(x) ? m[x] : ERASED_BYTE;
	endfunction
	task automatic wrc(input logic [15:0] x, input logic [7:0] y);
		@(posedge clk);
		wr <= 1'b1;
		addr <= x;
		wd <= y;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rdc(input logic [15:0] x, output logic [7:0] y);
		@(posedge clk);
		rd <= 1'b1;
		addr <= x;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		y = rdata;
	endtask
	task automatic unl();
		logic [3:0] n;
		n = 4'h8 + 4'($urandom % 8);
		wrc({n, CMD_OFS_A}, KEY_UNLOCK1);
		wrc({n, CMD_OFS_B}, KEY_UNLOCK2);
	endtask
	task automatic seq(input logic [7:0] c);
		unl();
		wrc({4'($urandom % 8) + 4'h8, CMD_OFS_A}, c);
	endtask
	task automatic setup(input logic [2:0] w, input logic [1:0] r);
		@(posedge clk);
		ctl <= 1'b1;
		wpm <= w;
		ar <= r;
		@(posedge clk);
		ctl <= 1'b0;
		cmt <= 1'b1;
		key <= COMMIT_KEY;
		@(posedge clk);
		cmt <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	// busy must stand for the whole count, then drop
	task automatic fin(input int lim);
		while (busy === 1'b1 && cyc - t0 < lim + 8) begin
			@(posedge clk);
			#1;
		end
		chk(busy, 1'b0);
		chk(cyc - t0 <= lim + 2 && cyc - t0 >= lim - 2, 1'b1);
	endtask
	// two reads back to back, so the toggle assertion sees consecutive reads
	task automatic toggles(input logic [15:0] x);
		@(posedge clk);
		rd <= 1'b1;
		addr <= x;
		@(posedge clk);
		#1;
		v = rdata;
		chk(v[TOGGLE_BIT], 1'b1);
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata[TOGGLE_BIT], 1'b0);
	endtask
	// cells written here need not be erased first (expected value is old AND new) and are reached through one view
	task automatic pgm(input logic [15:0] x, input logic [7:0] y);
		seq(CMD_PROGRAM);
		wrc(x, y);
		t0 = cyc;
		chk(prog, 1'b1);
		chk({aaddr, awd}, {x, y});
		m[x] = mv(x) & y;
		fin(PROG_CYCLES);
	endtask
	task automatic era(input logic [7:0] c, input logic [15:0] x);
		seq(CMD_ERASE_SETUP);
		unl();
		wrc(x, c);
		t0 = cyc;
	endtask
	initial begin
		void'($urandom(68));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({busy, cen, idm, sec}, 4'h0);
		seq(CMD_PROGRAM);
		wrc(16'h9000, 8'h12);
		chk({busy, prog}, 2'b00);
		rdc(16'h9000, v);
		chk(v, ERASED_BYTE);
		setup(WP_ENABLE, AREA_DATA);
		chk({cen, aact}, {1'b1, AREA_DATA});
		a = {1'b1, 15'($urandom)};
		d = 8'($urandom);
		seq(CMD_PROGRAM);
		wrc(a, d);
		t0 = cyc;
		chk({busy, prog}, 2'b11);
		toggles(a);
		seq(CMD_PROGRAM);
		wrc(a ^ 16'h0001, 8'h00);
		chk(prog, 1'b0);
		m[a] = d;
		fin(PROG_CYCLES);
		rdc(a, v);
		chk(v, mv(a));
		wrc(16'hF555, KEY_UNLOCK1);
		wrc(16'hFAAA, KEY_UNLOCK1);
		wrc(16'hF555, CMD_PROGRAM);
		wrc(16'hC000, 8'h00);
		chk(busy, 1'b0);
		seq(CMD_PROGRAM);
		wrc(16'h7F00, 8'h00);
		chk(busy, 1'b0);
		b = 16'h8400 + 16'(($urandom % 30) * 1024);
		pgm(b + 16'h03FF, 8'h00);
		pgm(b + 16'h0400, 8'h5A);
		setup(WP_ENABLE, AREA_CODE);
		chk(aact, AREA_CODE);
		era(CMD_SECTOR, b + 16'($urandom % 1024));
		chk({busy, sect}, 2'b11);
		fin(ECNT);
		for (int k = 0; k < 1024; k++) m.delete(b + 16'(k));
		rdc(b + 16'h03FF, v);
		chk(v, mv(b + 16'h03FF));
		rdc(b + 16'h0400, v);
		chk(v, mv(b + 16'h0400));
		opm <= MODE_PARALLEL;
		era(CMD_SECTOR, b);
		chk({busy, sect}, 2'b00);
		opm <= MODE_MCU;
		seq(CMD_ID_ENTRY);
		chk(idm, 1'b1);
		rdc(ID_VENDOR_ADDR, v);
		chk(v, 8'h5A);
		rdc(ID_FLASH_ADDR, v);
		chk(v, 8'h3C);
		rdc(SEC_ADDR, v);
		chk(v, ERASED_BYTE);
		wrc(16'($urandom), CMD_ID_EXIT);
		chk(idm, 1'b0);
		rdc(b + 16'h0400, v);
		chk(v, mv(b + 16'h0400));
		seq(CMD_SECURITY);
		wrc(SEC_ADDR, SEC_DATA);
		t0 = cyc;
		chk(busy, 1'b1);
		toggles(b);
		fin(PROG_CYCLES);
		chk(sec, 1'b1);
		seq(CMD_ID_ENTRY);
		rdc(SEC_ADDR, v);
		chk(v == ERASED_BYTE, 1'b0);
		wrc(16'h0000, CMD_ID_EXIT);
		req <= 1'b1;
		opm <= MODE_SERIAL;
		@(posedge clk);
		#1;
		chk({sok, rok}, 2'b00);
		opm <= MODE_MCU;
		@(posedge clk);
		#1;
		chk({sok, rok, sec}, 3'b111);
		opm <= MODE_PARALLEL;
		rdc(b + 16'h0400, v);
		chk(v, 8'h00);
		seq(CMD_ID_ENTRY);
		chk(idm, 1'b0);
		opm <= MODE_MCU;
		era(CMD_CHIP, 16'hF555);
		chk({busy, chip}, 2'b11);
		toggles(b);
		fin(ECNT);
		m.delete();
		chk(sec, 1'b0);
		rdc(b + 16'h0400, v);
		chk(v, mv(b + 16'h0400));
		setup(WP_DISABLE, AREA_DATA);
		chk({cen, aact}, {1'b0, AREA_DATA});
		seq(CMD_PROGRAM);
		wrc(b, 8'h00);
		chk({busy, prog}, 2'b00);
		stop_test();
	end
endmodule
`default_nettype wire
